// >>> design/cx_exec.sv
// Register operate, shift and flag instruction executor with AHB-Lite slave
`timescale 1ns/1ns
`include "cx_defines.svh"

// How it works
// - Register operate takes any source and any destination accumulator
// - Add and add-with-carry store sum, update overflow and carry
// - And and exclusive-or of destination and source into destination
// - Complement-add-immediate: ones complement plus displacement
// - Shifts and rotates left or right by n places, with or without link
// - All-zero opcode halts; flag ops use prefix 0011, select, set bit
// - Set flag leaves bit at one; pulse raises it then clears it
// - Register operate four cycles, complement-add five, plus one extend
// - Shift takes five plus three per place; zero count takes six
// - Branch, jump, call and return times, indirect adds a read
// - Skip times, one more cycle when the skip occurs
// - Load, sign load, indirect load and store times
// - Memory operate four cycles two reads; decimal add seven
// - Register transfers four cycles; exchanges six
// - Sign load copies bit seven into the upper byte
// - Memory operate combines accumulator zero, or any accumulator for add, with operand, binary or BCD
// - One machine cycle is four clock periods
// - Each extend adds the stretch time; zero stretch adds nothing
module cx_exec
    import cx_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Processor state
    output logic [15:0]      flags_out,
    output logic             busy,
    output logic             halted
);

    cx_st_t    q;
    cx_st_t    d;
    logic [16:0] ni;
    logic [5:0]  opc;
    logic [15:0] a_d;
    logic [15:0] a_s;
    logic [15:0] a_m;
    logic [15:0] disp;
    cx_tim_t     tim;
    logic [11:0] total;
    logic [17:0] ar;
    logic [17:0] am;
    logic [17:0] sb;
    logic [16:0] bc;
    logic [16:0] sh;
    logic        issue;
    logic        done;
    logic [31:0] rmux;

    // Sum with signed overflow and carry out
    function automatic logic [17:0] addf(input logic [15:0] a,
                                         input logic [15:0] b,
                                         input logic        ci);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b} + {16'h0000, ci};
        return {(a[15] == b[15]) && (s[15] != a[15]), s};
    endfunction : addf

    // Four digit decimal add
    function automatic logic [16:0] bcd(input logic [15:0] a,
                                        input logic [15:0] b,
                                        input logic        ci);
        logic [4:0]  s;
        logic        c;
        logic [15:0] r;
        c = ci;
        r = 16'h0000;
        for (int i = 0; i < 4; i++) begin
            s = {1'b0, a[i*4+:4]} + {1'b0, b[i*4+:4]} + {4'h0, c};
            c = s > 5'h09;
            if (c) begin
                s = s + 5'h06;
            end
            r[i*4+:4] = s[3:0];
        end
        return {c, r};
    endfunction : bcd

    // One place per step; link sits in bit 16
    function automatic logic [16:0] shf(input logic [16:0] v0,
                                        input logic [1:0]  k,
                                        input logic [6:0]  n,
                                        input logic        lk);
        logic [16:0] v;
        v = v0;
        for (int i = 0; i < 127; i++) begin
            if (7'(i) < n) begin
                if (!k[0]) begin
                    v = lk ? {v[15:0], k[1] ? 1'b0 : v[16]}
                           : {v[16], v[14:0], k[1] ? 1'b0 : v[15]};
                end else begin
                    v = lk ? {k[1] ? 1'b0 : v[0], v[16:1]}
                           : {v[16], k[1] ? 1'b0 : v[0], v[15:1]};
                end
            end
        end
        return v;
    endfunction : shf

    // Execution time in machine cycles and extends
    function automatic cx_tim_t cx_time(input logic [15:0] w);
        cx_tim_t t;
        t = '{9'h004, 2'h1, 1'b0, 1'b0};
        casez (w[`CX_OPC])
            6'b0100??:         t = '{9'h005, 2'h1, 1'b0, 1'b1};
            6'b100110:         t = '{9'h004, 2'h2, 1'b0, 1'b0};
            6'b000101, 6'b100000:
                               t = '{9'h005, 2'h1, 1'b0, 1'b0};
            6'b100101:         t = '{9'h005, 2'h2, 1'b0, 1'b0};
            6'b011111:         t = '{9'h006, 2'h1, 1'b0, 1'b0};
            6'b1111??, 6'b101110:
                               t = '{9'h005, 2'h2, 1'b0, 1'b1};
            6'b100111:         t = '{9'h007, 2'h2, 1'b0, 1'b1};
            6'b100011, 6'b101011:
                               t = '{9'h007, 2'h2, 1'b1, 1'b1};
            6'b011110:         t = '{9'h005, 2'h1, 1'b0, 1'b1};
            6'b1100??, 6'b101111:
                               t = '{9'h004, 2'h2, 1'b0, 1'b0};
            6'b1101??:         t = '{9'h004, 2'h1, 1'b1, 1'b0};
            6'b101100:         t = '{9'h004, 2'h2, 1'b1, 1'b0};
            6'b101010, 6'b101001, 6'b1110??, 6'b101000:
                               t = '{9'h004, 2'h2, 1'b0, 1'b0};
            6'b100010:         t = '{9'h007, 2'h2, 1'b0, 1'b0};
            6'b011011, 6'b000111:
                               t = '{9'h006, 2'h1, 1'b0, 1'b0};
            6'b011100:         t = '{9'h005, 2'h1, 1'b0, 1'b0};
            6'b0010??: begin
                t.m = (w[`CX_SCNT] == 7'h00) ? 9'h006
                    : 9'h005 + 9'h003 * {2'b00, w[`CX_SCNT]};
            end
            6'b0011??:
                t.m = w[`CX_FSET] ? 9'h005 : 9'h006;
            default: ;
        endcase
        return t;
    endfunction : cx_time

    always_comb begin
        case (haddr[7:0])
            `CX_A_INSTR:  rmux = {15'h0000, q.instr};
            `CX_A_OPND:   rmux = {16'h0000, q.opnd};
            `CX_A_ACC0:   rmux = {16'h0000, q.acc[0]};
            `CX_A_ACC1:   rmux = {16'h0000, q.acc[1]};
            `CX_A_ACC2:   rmux = {16'h0000, q.acc[2]};
            `CX_A_ACC3:   rmux = {16'h0000, q.acc[3]};
            `CX_A_FLAGS:  rmux = {16'h0000, q.flags};
            `CX_A_EXT:    rmux = {16'h0000, q.ext};
            `CX_A_STAT:   rmux = {30'h00000000, q.st == CX_HALT,
                                  q.st == CX_EXEC};
            `CX_A_CYCLES: rmux = {20'h00000, q.cycles};
            default:      rmux = 32'h00000000;
        endcase
    end

    always_comb begin
        d     = q;
        ni    = hwdata[16:0];
        opc   = ni[`CX_OPC];
        a_d   = q.acc[ni[`CX_DR]];
        a_s   = q.acc[ni[`CX_SR]];
        a_m   = q.acc[ni[`CX_MR]];
        disp  = {{8{ni[7]}}, ni[`CX_DISP]};
        tim   = cx_time(ni[15:0]);
        total = 12'(tim.m) * 12'(`CX_M_CLKS)
              + 12'(tim.nr) * 12'(q.ext[`CX_EXT_R])
              + (tim.nw ? 12'(q.ext[`CX_EXT_W]) : 12'h000)
              + ((tim.cx && ni[`CX_COND]) ? 12'(`CX_M_CLKS) : 12'h000);
        ar    = addf(a_d, a_s, opc[0] & q.flags[`CX_FLG_CY]);
        am    = addf(a_m, q.opnd, 1'b0);
        sb    = addf(q.acc[0], ~q.opnd, q.flags[`CX_FLG_CY]);
        bc    = bcd(q.acc[0], q.opnd, q.flags[`CX_FLG_CY]);
        sh    = shf({q.flags[`CX_FLG_LINK], a_d}, opc[1:0],
                    ni[`CX_SCNT], ni[`CX_SLNK]);
        issue = q.wr_pend && q.wr_addr == `CX_A_INSTR && q.st == CX_IDLE;
        // Address phase
        d.wr_pend = hsel && hready && htrans[1] && hwrite;
        d.wr_addr = haddr[7:0];
        if (hsel && hready && htrans[1] && !hwrite) begin
            d.hrdata = rmux;
        end
        // Data phase writes; state held by execution is locked
        if (q.wr_pend) begin
            case (q.wr_addr)
                `CX_A_OPND: d.opnd = hwdata[15:0];
                `CX_A_EXT:  d.ext  = hwdata[15:0];
                `CX_A_ACC0, `CX_A_ACC1, `CX_A_ACC2, `CX_A_ACC3:
                    if (q.st != CX_EXEC) begin
                        d.acc[2'(q.wr_addr[4:2] - 3'h2)] = hwdata[15:0];
                    end
                `CX_A_FLAGS:
                    if (q.st != CX_EXEC) begin
                        d.flags = hwdata[15:0];
                    end
                default: ;
            endcase
        end
        case (q.st)
            CX_IDLE: if (issue) begin
                d.instr   = ni;
                d.acc_res = q.acc;
                d.flg_res = q.flags;
                d.cnt     = total - 12'h001;
                d.cycles  = total;
                d.st      = CX_EXEC;
                casez (opc)
                    6'b011010, 6'b011101: begin
                        d.acc_res[ni[`CX_DR]]  = ar[15:0];
                        d.flg_res[`CX_FLG_CY] = ar[16];
                        d.flg_res[`CX_FLG_OV] = ar[17];
                    end
                    6'b010101: d.acc_res[ni[`CX_DR]] = a_d & a_s;
                    6'b010110: d.acc_res[ni[`CX_DR]] = a_d ^ a_s;
                    6'b011100: d.acc_res[ni[`CX_DR]] = ~a_d + disp;
                    6'b0010??: begin
                        d.acc_res[ni[`CX_DR]] = sh[15:0];
                        if (ni[`CX_SLNK]) begin
                            d.flg_res[`CX_FLG_LINK] = sh[16];
                        end
                    end
                    6'b0011??: begin
                        d.flg_res[ni[`CX_FC]] = ni[`CX_FSET];
                        d.flags[ni[`CX_FC]]   = 1'b1;
                    end
                    6'b000000: d.st = CX_HALT;
                    6'b101010: d.acc_res[0] = q.acc[0] & q.opnd;
                    6'b101001: d.acc_res[0] = q.acc[0] | q.opnd;
                    6'b1110??: begin
                        d.acc_res[ni[`CX_MR]]  = am[15:0];
                        d.flg_res[`CX_FLG_CY] = am[16];
                        d.flg_res[`CX_FLG_OV] = am[17];
                    end
                    6'b101000: begin
                        d.acc_res[0]          = sb[15:0];
                        d.flg_res[`CX_FLG_CY] = sb[16];
                        d.flg_res[`CX_FLG_OV] = sb[17];
                    end
                    6'b100010: begin
                        d.acc_res[0]          = bc[15:0];
                        d.flg_res[`CX_FLG_CY] = bc[16];
                        d.flg_res[`CX_FLG_OV] = bc[16];
                    end
                    6'b101111: d.acc_res[0] =
                        {{8{q.opnd[7]}}, q.opnd[7:0]};
                    6'b1100??: d.acc_res[ni[`CX_MR]] = q.opnd;
                    6'b010100: d.acc_res[ni[`CX_DR]] = disp;
                    6'b010111: d.acc_res[ni[`CX_DR]] = a_s;
                    6'b011011: begin
                        d.acc_res[ni[`CX_DR]] = a_s;
                        d.acc_res[ni[`CX_SR]] = a_d;
                    end
                    default: ;
                endcase
            end
            CX_EXEC: if (q.cnt == 12'h000) begin
                d.acc   = q.acc_res;
                d.flags = q.flg_res;
                d.st    = CX_IDLE;
            end else begin
                d.cnt = q.cnt - 12'h001;
            end
            CX_HALT: if (q.wr_pend && q.wr_addr == `CX_A_STAT
                         && hwdata[`CX_ST_HALT]) begin
                d.st = CX_IDLE;
            end
            default: d.st = CX_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q       <= '0;
            q.st    <= CX_IDLE;
            q.flags <= `CX_RST_FLAGS;
            q.ext   <= `CX_RST_EXT;
        end else begin
            q <= d;
        end
    end

    assign hrdata    = q.hrdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign flags_out = q.flags;
    assign busy      = q.st == CX_EXEC;
    assign halted    = q.st == CX_HALT;
    assign done      = q.st == CX_EXEC && q.cnt == 12'h000;

    // Checker state captured at issue
    logic [11:0] h_cyc;
    logic [5:0]  h_op;
    logic [15:0] h_a;
    logic [15:0] h_b;
    logic [1:0]  h_dr;
    logic [3:0]  h_fc;
    logic        h_set;
    logic        h_cy;
    logic        h_ov;
    logic [6:0]  h_n;
    logic [7:0]  h_er;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            h_cyc <= 12'h000;
            h_op  <= 6'h00;
            h_a   <= 16'h0000;
            h_b   <= 16'h0000;
            h_dr  <= 2'h0;
            h_fc  <= 4'h0;
            h_set <= 1'b0;
            h_cy  <= 1'b0;
            h_ov  <= 1'b0;
            h_n   <= 7'h00;
            h_er  <= 8'h00;
        end else if (issue) begin
            h_cyc <= 12'h000;
            h_op  <= opc;
            h_a   <= a_d;
            h_b   <= (opc == 6'h1c) ? disp : opc[5] ? q.opnd : a_s;
            h_dr  <= ni[`CX_DR];
            h_fc  <= ni[`CX_FC];
            h_set <= ni[`CX_FSET];
            h_cy  <= q.flags[`CX_FLG_CY];
            h_ov  <= q.flags[`CX_FLG_OV];
            h_n   <= ni[`CX_SCNT];
            h_er  <= q.ext[`CX_EXT_R];
        end else if (busy) begin
            h_cyc <= h_cyc + 12'h001;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence pulse_start;
        issue && hwdata[15:12] == 4'b0011 && !hwdata[`CX_FSET];
    endsequence
    sequence pulse_end;
        done && h_op[5:2] == 4'b0011 && !h_set;
    endsequence

    regop_time_a: assert property (done && (h_op == 6'h1a || h_op == 6'h1d
        || h_op == 6'h15 || h_op == 6'h16)
        |-> h_cyc + 12'h001 == 12'd16 + 12'(h_er))
        else $error("register operate time wrong");
    cai_time_a: assert property (done && h_op == 6'h1c
        |-> h_cyc + 12'h001 == 12'd20 + 12'(h_er))
        else $error("complement add time wrong");
    shift_time_a: assert property (done && h_op[5:2] == 4'b0010
        |-> h_cyc + 12'h001 == (h_n == 7'h00 ? 12'd24
            : 12'd20 + 12'd12 * 12'(h_n)) + 12'(h_er))
        else $error("shift time wrong");
    xch_time_a: assert property (done && (h_op == 6'h1b || h_op == 6'h07)
        |-> h_cyc + 12'h001 == 12'd24 + 12'(h_er))
        else $error("exchange time wrong");
    add_res_a: assert property (done && h_op == 6'h1a
        |=> {q.flags[`CX_FLG_CY], q.acc[h_dr]} == {1'b0, h_a} + {1'b0, h_b})
        else $error("register add result wrong");
    and_res_a: assert property (done && h_op == 6'h15
        |=> q.acc[h_dr] == (h_a & h_b))
        else $error("register and result wrong");
    cai_res_a: assert property (done && h_op == 6'h1c
        |=> q.acc[h_dr] == ~h_a + h_b)
        else $error("complement add result wrong");
    // A flag op that selects carry or overflow may change that bit itself
    keep_cy_a: assert property (done && (h_op == 6'h15 || h_op == 6'h16
        || h_op == 6'h1c || (h_op[5:2] == 4'b0011
            && h_fc != 4'(`CX_FLG_OV) && h_fc != 4'(`CX_FLG_CY)))
        |=> q.flags[`CX_FLG_CY] == h_cy && q.flags[`CX_FLG_OV] == h_ov)
        else $error("carry or overflow disturbed");
    pulse_a: assert property (pulse_start |=> q.flags[h_fc] && busy)
        else $error("pulse flag not raised");
    pulse_low_a: assert property (pulse_end |=> !q.flags[h_fc] && !busy)
        else $error("pulse flag not returned");
    halt_a: assert property (issue && hwdata[15:10] == 6'h00
        |=> halted ##1 (halted || !busy))
        else $error("halt not taken");
    load_sign_extend_op_a: assert property (done && h_op == 6'h2f
        |=> q.acc[0] == {{8{h_b[7]}}, h_b[7:0]})
        else $error("sign extension wrong");

endmodule : cx_exec

// >>> design/cx_defines.svh
// Offsets, field positions, reset values and timing counts of the executor
`ifndef CX_DEFINES_SVH
`define CX_DEFINES_SVH

// Clock periods in one machine cycle
`define CX_M_CLKS     4

// Register byte addresses
`define CX_A_INSTR    8'h00
`define CX_A_OPND     8'h04
`define CX_A_ACC0     8'h08
`define CX_A_ACC1     8'h0c
`define CX_A_ACC2     8'h10
`define CX_A_ACC3     8'h14
`define CX_A_FLAGS    8'h18
`define CX_A_EXT      8'h1c
`define CX_A_STAT     8'h20
`define CX_A_CYCLES   8'h24

// Instruction word fields
`define CX_OPC        15:10
`define CX_DR         9:8
`define CX_SR         7:6
`define CX_MR         11:10
`define CX_FC         11:8
`define CX_FSET       7
`define CX_SCNT       7:1
`define CX_SLNK       0
`define CX_DISP       7:0
`define CX_COND       16

// Extend register and status fields
`define CX_EXT_R      7:0
`define CX_EXT_W      15:8
`define CX_ST_BUSY    0
`define CX_ST_HALT    1

// Flag register bit positions
`define CX_FLG_LINK   2
`define CX_FLG_OV     3
`define CX_FLG_CY     4

// Reset values
`define CX_RST_FLAGS  16'h0000
`define CX_RST_EXT    16'h0000

`endif

// >>> design/cx_pkg.sv
// Types shared by the instruction executor
package cx_pkg;

    typedef enum logic [1:0] {
        CX_IDLE,
        CX_EXEC,
        CX_HALT
    } cx_state_t;

    // Machine cycles, read extends, write extend, conditional extra cycle
    typedef struct packed {
        logic [8:0] m;
        logic [1:0] nr;
        logic       nw;
        logic       cx;
    } cx_tim_t;

    typedef struct packed {
        cx_state_t        st;
        logic [3:0][15:0] acc;
        logic [3:0][15:0] acc_res;
        logic [15:0]      flags;
        logic [15:0]      flg_res;
        logic [16:0]      instr;
        logic [15:0]      opnd;
        logic [15:0]      ext;
        logic [11:0]      cnt;
        logic [11:0]      cycles;
        logic [31:0]      hrdata;
        logic             wr_pend;
        logic [7:0]       wr_addr;
    } cx_st_t;

endpackage : cx_pkg

// >>> tb/cx_prog_rom.sv
// Program memory model handing out instruction words
`timescale 1ns/1ns
module cx_prog_rom (
    // Fetch
    input  wire logic [3:0]  idx,
    output logic      [16:0] word
);
    // Bit 16 is the branch or skip outcome
    always_comb begin
        case (idx)
            4'h0: word = 17'h01800;
            4'h1: word = 17'h09800;
            4'h2: word = 17'h01400;
            4'h3: word = 17'h07c00;
            4'h4: word = 17'h14000;
            4'h5: word = 17'h04000;
            4'h6: word = 17'h18c00;
            4'h7: word = 17'h0d000;
            4'h8: word = 17'h08800;
            4'h9: word = 17'h06c00;
            default: word = 17'h05000;
        endcase
    end
endmodule : cx_prog_rom

// >>> tb/test_cx_exec.sv
// Self-checking bench of the register operate, shift and flag executor
`timescale 1ns/1ns
`include "cx_defines.svh"
module test_cx_exec;
    logic        hclk, hresetn, hsel, hwrite, hready;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, busy, halted;
    logic [15:0] flags_out, fl, fb, m, v;
    logic [15:0] acc [4];
    logic [17:0] x;
    logic [16:0] w, y;
    logic [7:0]  dp;
    logic [3:0]  idx;
    logic [5:0]  rop [4] = '{6'h1a, 6'h1d, 6'h15, 6'h16};
    logic [5:0]  sop [4] = '{6'h0a, 6'h0b, 6'h08, 6'h09};
    int          n_fail, checks, seed, er, ew, n, d, s, r, sc, fc;

    assign hready = hreadyout;

    cx_exec dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .flags_out(flags_out),
        .busy(busy), .halted(halted));

    cx_prog_rom rom_u (.idx(idx), .word(w));

    always #2 hclk = ~hclk;

    task check(input logic [31:0] got, exp, input string msg);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg,
                got, exp);
        end
    endtask : check

    task stop_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // One single word transfer, entered just after a rising edge
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] dat);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= dat;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    function int t_of(logic [16:0] iw);
        int c;
        c = iw[16] ? 4 : 0;
        casez (iw[15:10])
            6'b0100??: return 20 + er + c;
            6'b1101??: return 16 + er + ew;
            6'b0011??: return iw[7] ? 20 + er : 24 + er;
            6'b0010??: return iw[7:1] != 0 ? 20 + 12 * iw[7:1] + er : 24 + er;
            6'h05, 6'h1c: return 20 + er;
            6'h1b, 6'h1f: return 24 + er;
            6'h26, 6'h2a, 6'h2f: return 16 + 2 * er;
            6'h22: return 28 + 2 * er;
            6'h23: return 28 + 2 * er + ew + c;
            default: return 16 + er;
        endcase
    endfunction : t_of

    function logic [17:0] reg_res(logic [5:0] op, logic [15:0] a, b, f);
        logic [16:0] sm;
        sm = {1'b0, a} + {1'b0, b} + {16'h0, op == 6'h1d && f[4]};
        case (op)
            6'h15: return {f[3], f[4], a & b};
            6'h16: return {f[3], f[4], a ^ b};
            default: return {a[15] == b[15] && sm[15] != a[15], sm[16],
                sm[15:0]};
        endcase
    endfunction : reg_res

    // Link in bit 16; with the link option the value is 17 bits wide
    function logic [16:0] sh_res(logic [5:0] op, logic [16:0] a, int k,
                                 logic l);
        int          wd;
        logic [16:0] p;
        wd = l ? 17 : 16;
        p = l ? a : {1'b0, a[15:0]};
        case (op)
            6'h0a: p = p << k;
            6'h0b: p = p >> k;
            6'h08: p = (p << k) | (p >> (wd - k));
            default: p = (p >> k) | (p << (wd - k));
        endcase
        return l ? p : {a[16], p[15:0]};
    endfunction : sh_res

    // Issue, time the busy span and read back the cycle count
    task exec(input logic [16:0] iw);
        int t;
        t = t_of(iw);
        bus(1'b1, `CX_A_INSTR, {15'h0, iw});
        n = 0;
        #1;
        fb = flags_out;
        while (busy === 1'b1 && n < 4000) begin
            @(posedge hclk);
            #1;
            n++;
        end
        check(n, t, "busy span");
        bus(1'b0, `CX_A_CYCLES, 32'h0);
        check(rd, t, "cycle count");
    endtask : exec

    task chk_acc(input int k, input logic [17:0] e);
        bus(1'b0, `CX_A_ACC0 + 8'(4 * k), 32'h0);
        check({14'h0, flags_out[3], flags_out[4], rd[15:0]}, {14'h0, e},
            "acc");
        acc[k] = e[15:0];
    endtask : chk_acc

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        idx = 4'h0;
        n_fail = 0;
        checks = 0;
        seed = 35807;
        repeat (2) @(posedge hclk);
        check({busy, halted, hresp, hreadyout, flags_out}, 32'h10000, "rst");
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, 8'h3c, 32'h0);
        check(rd, 32'h0, "unmapped");
        for (int i = 0; i < 16; i++) begin
            er = $random(seed) & 3;
            ew = $random(seed) & 3;
            bus(1'b1, `CX_A_EXT, {16'h0, 8'(ew), 8'(er)});
            for (int k = 0; k < 4; k++) begin
                acc[k] = 16'($random(seed));
                bus(1'b1, `CX_A_ACC0 + 8'(4 * k), {16'h0, acc[k]});
            end
            d = $random(seed) & 3;
            s = $random(seed) & 3;
            x = reg_res(rop[i % 4], acc[d], acc[s], flags_out);
            exec({1'b0, rop[i % 4], 2'(d), 2'(s), 6'($random(seed))});
            chk_acc(d, x);
            r = $random(seed) & 3;
            dp = 8'($random(seed));
            fl = flags_out;
            exec({1'b0, 6'h1c, 2'(r), dp});
            chk_acc(r, {fl[3], fl[4], ~acc[r] + {{8{dp[7]}}, dp}});
            sc = $random(seed) & 3;
            fl = flags_out;
            y = sh_res(sop[i % 4], {fl[2], acc[r]}, sc, i[1]);
            exec({1'b0, sop[i % 4], 2'(r), 7'(sc), i[1]});
            chk_acc(r, {fl[3], fl[4], y[15:0]});
            check(flags_out[2], y[16], "link");
            fc = $random(seed) & 15;
            fl = flags_out;
            exec({1'b0, 4'h3, 4'(fc), i[0], 7'($random(seed))});
            if (!i[0]) begin
                check(fb[fc], 1'b1, "pulse high");
            end
            m = 16'h1 << fc;
            check(flags_out, i[0] ? fl | m : fl & ~m, "flag");
        end
        for (int j = 0; j < 11; j++) begin
            idx = 4'(j);
            #1;
            exec(w);
        end
        for (int j = 0; j < 2; j++) begin
            v = {8'($random(seed)), 1'(j), 7'($random(seed))};
            bus(1'b1, `CX_A_OPND, {16'h0, v});
            exec(17'h0bc00);
            bus(1'b0, `CX_A_ACC0, 32'h0);
            check(rd, {16'h0, {8{v[7]}}, v[7:0]}, "sign load");
            exec(17'h0a800);
            bus(1'b0, `CX_A_ACC0, 32'h0);
            check(rd, {16'h0, {{8{v[7]}}, v[7:0]} & v}, "mem and");
        end
        bus(1'b1, `CX_A_INSTR, 32'h0);
        #1;
        check({busy, halted}, 2'b01, "halt");
        bus(1'b1, `CX_A_INSTR, 32'h6800);
        #1;
        check({busy, halted}, 2'b01, "halted refuse");
        bus(1'b1, `CX_A_STAT, 32'h2);
        #1;
        check(halted, 1'b0, "resume");
        stop_test();
    end

    initial begin
        #200000;
        n_fail++;
        stop_test();
    end
endmodule : test_cx_exec
